// ---- core/bzcd_pkg.sv ----
package bzcd_pkg;

	// Clock and sample timing.
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned SAMPLE_PERIOD_NS = 1250;
	localparam int unsigned SAMPLE_CYC = (SAMPLE_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned MASK_TIME_NS = 20000;
	localparam int unsigned MASK_CYC = (MASK_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned MIN_OFF_NS = 1250;
	localparam int unsigned MIN_OFF_CYC = (MIN_OFF_NS * CLK_MHZ + 999) / 1000;

	localparam int TICK_W = 6;
	localparam int MASK_W = 10;
	localparam int OFF_W = 12;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYC - 1);
	localparam logic [MASK_W-1:0] MASK_LAST = MASK_W'(MASK_CYC - 1);
	localparam logic [OFF_W-1:0] MIN_OFF_SENSOR = OFF_W'(MIN_OFF_CYC);

	// Register map, byte addresses.
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] MASK_ADDR = 8'h08;

	// Control register fields.
	localparam int CTRL_W = 11;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 11'h000;
	localparam int CTRL_SR = 0;
	localparam int CTRL_VCM = 1;
	localparam int CTRL_DAC = 2;
	localparam int CTRL_REO = 3;
	localparam int CTRL_ZVD = 4;
	localparam int CTRL_CPB = 5;
	localparam int CTRL_OS_LO = 6;
	localparam int CTRL_IS_LO = 9;

	// Status and mask register fields.
	localparam int STAT_ZCF = 0;
	localparam int STAT_HST = 1;
	localparam int STAT_CPB = 2;
	localparam int STAT_ST_LO = 3;
	localparam int MASK_ZIM = 0;

	typedef enum logic [2:0] {
		BZCD_WAIT_C,
		BZCD_MASK_D,
		BZCD_WAIT_D,
		BZCD_MASK_Z,
		BZCD_SAMPLE_Z
	} bzcd_state_t;

endpackage

// ---- core/bzcd_top.sv ----
`timescale 1ns/1ps
// Summary of operation
// - Sensorless: Z sampling starts only after C then D; PWM group may then move.
// - Sensorless: read only while PWM sits on the group chosen by group select, except config x11.
// - Z qualified by edge/level select and polarity, only on correct group.
// - Each Z sets the zero-cross flag; interrupt raised when its mask is set.
// - Each Z is passed as a trigger pulse to the delay manager.
// - Sensor mode: Z sensed on the one phase input chosen by input select.
// - Sensor mode: all demagnetization handling is disabled.
// - Sensor mode: Z accepted in any window, no phase configuration needed.
// - Sensor mode: selected input sampled at a fixed 800 kHz.
// - Sensor mode: current-control PWM minimum off time is 1.25 us.
// - Direct access mode holds the last synchronized sensor sample latched.
// - Mode 0: high config bit used, D sampled at 1.25 us, 20 us masks.
// - Mode 1: high config bit ignored, Z at 1.25 us, 20 us after C.
// - Current mode: x00 even, x01 odd, x10 read on group of group select.
// - Voltage mode: 000/100 even, 001/101 odd, 110 by group select.
// - Config x11: PWM on both groups, read on either group.
// - Sensor mode: reading permitted on either group for every config.
// - Any combination not listed forbids a back-EMF reading.
// - Polarity writes are buffered and applied at the next commutation.
// - Sensorless Z rate: window tick in current mode, timer PWM in voltage.
module bzcd_top #(
	parameter logic [bzcd_pkg::OFF_W-1:0] MIN_OFF_SENSORLESS = 12'h064
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [bzcd_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Motor pins and comparator
	input wire logic phase_input_a,
	input wire logic phase_input_b,
	input wire logic phase_input_c,
	input wire logic bemf_cmp_in,
	// Events and PWM state from neighbouring logic
	input wire logic comm_evt,
	input wire logic demag_evt,
	input wire logic pwm_on_even,
	input wire logic pwm_on_odd,
	input wire logic window_sample_tick,
	input wire logic timer_pwm_sample,
	// Results
	output logic z_event,
	output logic zero_cross_irq,
	output logic demag_enable,
	output logic demag_sample_tick,
	output logic after_d_phase,
	output logic [2:0] pwm_cfg_eff,
	output logic [bzcd_pkg::OFF_W-1:0] min_off_cycles
);
	import bzcd_pkg::*;

	logic [CTRL_W-1:0] ctrl;
	logic zero_cross_irq_mask;
	logic zero_cross_flag;
	logic latched_sensor_level;
	logic cpb_act;
	bzcd_state_t state;
	logic [MASK_W-1:0] mask_cnt;
	logic [TICK_W-1:0] tick_cnt;
	logic tick;
	logic [3:0] sync1;
	logic [3:0] sync2;
	logic prev_val;
	logic prev_ok;

	logic sr;
	logic vcm;
	logic dac;
	logic bemf_read_group_select;
	logic edge_level_select;
	logic [2:0] os;
	logic [1:0] input_select;
	logic sel_sensor;
	logic strobe;
	logic sample_val;
	logic permit;
	logic accept;
	logic z_hit;
	logic setup;
	logic wr_en;
	logic addr_ok;
	logic [31:0] rdata;

	assign sr = ctrl[CTRL_SR];
	assign vcm = ctrl[CTRL_VCM];
	assign dac = ctrl[CTRL_DAC];
	assign bemf_read_group_select = ctrl[CTRL_REO];
	assign edge_level_select = ctrl[CTRL_ZVD];
	assign os = ctrl[CTRL_OS_LO +: 3];
	assign input_select = ctrl[CTRL_IS_LO +: 2];

	// Back-EMF read permission for a given mode, config and group select.
	function automatic logic read_ok(input logic f_sr, input logic f_vcm,
		input logic [2:0] f_os, input logic f_reo, input logic f_even,
		input logic f_odd);
		logic grp;
		grp = f_reo ? f_odd : f_even;
		if (f_sr) begin
			read_ok = 1'h1;
		end else if (f_os[1:0] == 2'h3) begin
			read_ok = f_even | f_odd;
		end else if (f_vcm) begin
			unique case (f_os[1:0])
				2'h0: read_ok = !f_reo && f_even;
				2'h1: read_ok = f_reo && f_odd;
				default: read_ok = grp;
			endcase
		end else begin
			unique case (f_os)
				3'h0, 3'h4: read_ok = !f_reo && f_even;
				3'h1, 3'h5: read_ok = f_reo && f_odd;
				3'h6: read_ok = grp;
				default: read_ok = 1'h0;
			endcase
		end
	endfunction

	// Input mux; select code 3 falls back to the first phase input.
	function automatic logic pick_phase(input logic [1:0] f_is,
		input logic [2:0] f_ph);
		unique case (f_is)
			2'h1: pick_phase = f_ph[1];
			2'h2: pick_phase = f_ph[2];
			default: pick_phase = f_ph[0];
		endcase
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end else begin
			sync1 <= {bemf_cmp_in, phase_input_c, phase_input_b, phase_input_a};
			sync2 <= sync1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= '0;
			tick <= 1'h0;
		end else begin
			tick <= (tick_cnt == TICK_LAST);
			tick_cnt <= (tick_cnt == TICK_LAST) ? '0 : tick_cnt + 1'h1;
		end
	end

	assign sel_sensor = pick_phase(input_select, sync2[2:0]);
	assign strobe = sr ? tick : (vcm ? window_sample_tick : timer_pwm_sample);
	assign sample_val = sr ? sel_sensor : sync2[3];
	assign permit = read_ok(sr, vcm, os, bemf_read_group_select, pwm_on_even, pwm_on_odd);
	assign accept = (state == BZCD_SAMPLE_Z) && strobe && permit;
	assign z_hit = accept && (edge_level_select ? (sample_val == cpb_act)
		: (prev_ok && (prev_val != cpb_act) && (sample_val == cpb_act)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= BZCD_WAIT_C;
			mask_cnt <= '0;
		end else if (comm_evt) begin
			mask_cnt <= '0;
			state <= sr ? BZCD_MASK_Z : BZCD_MASK_D;
		end else begin
			unique case (state)
				BZCD_WAIT_C: mask_cnt <= '0;
				BZCD_MASK_D: begin
					if (mask_cnt == MASK_LAST) begin
						state <= BZCD_WAIT_D;
					end
					mask_cnt <= mask_cnt + 1'h1;
				end
				BZCD_WAIT_D: begin
					mask_cnt <= '0;
					if (sr) begin
						state <= BZCD_SAMPLE_Z;
					end else if (demag_evt) begin
						state <= BZCD_MASK_Z;
					end
				end
				BZCD_MASK_Z: begin
					if (mask_cnt == MASK_LAST) begin
						state <= BZCD_SAMPLE_Z;
					end
					mask_cnt <= mask_cnt + 1'h1;
				end
				BZCD_SAMPLE_Z: begin
					mask_cnt <= '0;
					if (z_hit) begin
						state <= BZCD_WAIT_C;
					end
				end
				default: state <= BZCD_WAIT_C;
			endcase
		end
	end

	// Edge detection needs one accepted sample of history in this window.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_val <= 1'h0;
			prev_ok <= 1'h0;
		end else if (state != BZCD_SAMPLE_Z) begin
			prev_ok <= 1'h0;
		end else if (accept) begin
			prev_val <= sample_val;
			prev_ok <= 1'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpb_act <= 1'h0;
		end else if (comm_evt) begin
			cpb_act <= ctrl[CTRL_CPB];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_sensor_level <= 1'h0;
		end else if (!dac && tick) begin
			latched_sensor_level <= sel_sensor;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			z_event <= 1'h0;
		end else begin
			z_event <= z_hit;
		end
	end

	// Mode-dependent status outputs to the PWM and demag logic.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			demag_enable <= 1'h0;
			demag_sample_tick <= 1'h0;
			after_d_phase <= 1'h0;
			pwm_cfg_eff <= 3'h0;
			min_off_cycles <= MIN_OFF_SENSORLESS;
		end else begin
			demag_enable <= !sr && (state == BZCD_WAIT_D);
			demag_sample_tick <= !sr && tick;
			after_d_phase <= sr || (state == BZCD_MASK_Z) || (state == BZCD_SAMPLE_Z);
			pwm_cfg_eff <= sr ? {1'h0, os[1:0]} : os;
			min_off_cycles <= sr ? MIN_OFF_SENSOR : MIN_OFF_SENSORLESS;
		end
	end

	// APB: setup cycle arms pready, so every access completes in one cycle.
	assign setup = psel && !penable;
	assign wr_en = psel && penable && pready && pwrite && addr_ok;
	assign addr_ok = (paddr == CTRL_ADDR) || (paddr == STATUS_ADDR)
		|| (paddr == MASK_ADDR);

	always_comb begin
		rdata = 32'h0;
		unique case (paddr)
			CTRL_ADDR: rdata[CTRL_W-1:0] = ctrl;
			STATUS_ADDR: begin
				rdata[STAT_ZCF] = zero_cross_flag;
				rdata[STAT_HST] = latched_sensor_level;
				rdata[STAT_CPB] = cpb_act;
				rdata[STAT_ST_LO +: 3] = state;
			end
			MASK_ADDR: rdata[MASK_ZIM] = zero_cross_irq_mask;
			default: rdata = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0;
		end else begin
			pready <= setup;
			pslverr <= setup && !addr_ok;
			if (setup) begin
				prdata <= rdata;
			end
		end
	end

	// Software-written control and mask.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RESET;
			zero_cross_irq_mask <= 1'h0;
		end else if (wr_en) begin
			if (paddr == CTRL_ADDR) begin
				ctrl <= pwdata[CTRL_W-1:0];
			end
			if (paddr == MASK_ADDR) begin
				zero_cross_irq_mask <= pwdata[MASK_ZIM];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			zero_cross_flag <= 1'h0;
			zero_cross_irq <= 1'h0;
		end else begin
			// A new crossing beats a write-one-to-clear in the same cycle.
			if (z_hit) begin
				zero_cross_flag <= 1'h1;
			end else if (wr_en && (paddr == STATUS_ADDR) && pwdata[STAT_ZCF]) begin
				zero_cross_flag <= 1'h0;
			end
			zero_cross_irq <= zero_cross_flag && zero_cross_irq_mask;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_Z_AFTER_SEQ: assert property (
		z_event |-> $past(state) == BZCD_SAMPLE_Z
		&& (state == BZCD_WAIT_C || $past(comm_evt)))
		else $error("Z event outside sampling window");
	AST_FLAG_SET: assert property (
		z_hit |=> zero_cross_flag ##1 (zero_cross_irq == zero_cross_irq_mask))
		else $error("Flag or interrupt missing after Z");
	AST_ZEVT_PULSE: assert property (
		z_hit |=> z_event ##1 !z_event)
		else $error("Z trigger not a single pulse");
	AST_FORBIDDEN: assert property (
		(!sr && !vcm && os == 3'h2) |-> !accept)
		else $error("Reading accepted in forbidden config");
	AST_MASK_LEN: assert property (
		(state == BZCD_SAMPLE_Z && $past(state) == BZCD_MASK_Z)
		|-> $past(mask_cnt) == MASK_LAST)
		else $error("Mask window length wrong");
	AST_SENSOR_RATE: assert property (
		(sr && accept) |-> tick && $past(tick_cnt) == TICK_LAST)
		else $error("Sensor sample off the fixed tick");
	AST_CPB_HOLD: assert property (
		!comm_evt |=> $stable(cpb_act))
		else $error("Polarity changed without commutation");
	AST_HST_HOLD: assert property (
		dac |=> $stable(latched_sensor_level))
		else $error("Sensor level moved in direct access");
	AST_NO_DEMAG: assert property (
		sr |=> !demag_enable && !demag_sample_tick)
		else $error("Demag active in sensor mode");

	COV_Z_SENSOR: cover property (sr && z_hit);
	COV_Z_SENSORLESS: cover property (!sr && z_hit);
	COV_D_SEEN: cover property (state == BZCD_WAIT_D && demag_evt && !comm_evt);
	COV_FLAG_CLR: cover property (zero_cross_flag ##1 !zero_cross_flag);

endmodule

// ---- bench/bzcd_phase_model.sv ----
`timescale 1ns/1ps
// Sensor and comparator side; unselected sensors show the inverse level.
module bzcd_phase_model (
	// Clock
	input wire logic pclk,
	// Bench commands
	input wire logic [1:0] sel,
	input wire logic level,
	// Pins
	output logic phase_input_a,
	output logic phase_input_b,
	output logic phase_input_c,
	output logic bemf_cmp_in
);
	initial begin
		{phase_input_a, phase_input_b, phase_input_c, bemf_cmp_in} = 4'h0;
	end
	always @(posedge pclk) begin
		phase_input_a <= (sel == 2'd0 || sel == 2'd3) ? level : ~level;
		phase_input_b <= (sel == 2'd1) ? level : ~level;
		phase_input_c <= (sel == 2'd2) ? level : ~level;
		bemf_cmp_in <= level;
	end
endmodule

// ---- bench/bemf_zero_cross_detector_bench.sv ----
`timescale 1ns/1ps
module bemf_zero_cross_detector_bench;
	import bzcd_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pa, pb, pc, cmp, comm_evt, demag_evt, even, odd, lvl, vcm, bemf_read_group_select, edge_level_select, pol;
	logic wtick = 1'b0;
	logic ttick = 1'b0;
	logic [2:0] tcnt = 3'h0;
	logic z_event, irq, dem_en, dem_tick, after_d;
	logic [2:0] cfg_eff, os;
	logic [OFF_W-1:0] min_off;
	logic [1:0] sel;
	int fail_count, checks, got;

	bzcd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .phase_input_a(pa), .phase_input_b(pb),
		.phase_input_c(pc), .bemf_cmp_in(cmp), .comm_evt(comm_evt),
		.demag_evt(demag_evt), .pwm_on_even(even), .pwm_on_odd(odd),
		.window_sample_tick(wtick), .timer_pwm_sample(ttick), .z_event(z_event),
		.zero_cross_irq(irq), .demag_enable(dem_en), .demag_sample_tick(dem_tick),
		.after_d_phase(after_d), .pwm_cfg_eff(cfg_eff), .min_off_cycles(min_off));
	bzcd_phase_model u_model (.pclk(pclk), .sel(sel), .level(lvl), .phase_input_a(pa),
		.phase_input_b(pb), .phase_input_c(pc), .bemf_cmp_in(cmp));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// only the source of the current mode ticks
	always @(posedge pclk) begin
		tcnt <= tcnt + 3'h1;
		wtick <= (tcnt == 3'h0) && vcm;
		ttick <= (tcnt == 3'h0) && !vcm;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("ERROR %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	// Waits as long as the slave needs; only the watchdog ends a hung access.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// One-cycle event: d low gives a commutation, d high a demagnetization.
	task automatic pulse(input logic d);
		@(posedge pclk);
		comm_evt <= !d;
		demag_evt <= d;
		@(posedge pclk);
		{comm_evt, demag_evt} <= 2'b00;
	endtask
	task automatic wait_z(input int n);
		got = 0;
		repeat (n) begin
			@(posedge pclk);
			if (z_event === 1'b1) got = 1;
		end
	endtask
	function automatic logic [31:0] mk(int sr, int v, int dac, int r, int p, int o, int s);
		return 32'(sr << CTRL_SR | v << CTRL_VCM | dac << CTRL_DAC | r << CTRL_REO |
			p << CTRL_CPB | o << CTRL_OS_LO | s << CTRL_IS_LO);
	endfunction
	// Reading permission for the chosen mode, config and groups.
	function automatic int permit(logic v, logic [2:0] o, logic r, logic e, logic d);
		logic grp;
		grp = r ? d : e;
		if (o[1:0] == 2'b11) return int'(e | d);
		if (v) return (o[1] || o[0] == r) ? int'(grp) : 0;
		if (o == 3'b110) return int'(grp);
		return (!o[1] && o[0] == r) ? int'(grp) : 0;
	endfunction
	task automatic summarize;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#1500000;
		fail_count++;
		$display("ERROR %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{comm_evt, demag_evt, even, odd, lvl, vcm, bemf_read_group_select, edge_level_select, pol, os, sel} = '0;
		void'($urandom(32'hb738));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, CTRL_ADDR, 0);
		chk(rd, 32'(CTRL_RESET), "ctrl reset");
		apb(0, 8'h0c, 0);
		chk({rd[30:0], err}, 1, "unmapped");
		$display("test registers done");
		sel <= 2'd1;
		apb(1, MASK_ADDR, 1);
		apb(1, CTRL_ADDR, mk(1, 0, 0, $urandom % 2, 1, 7, 1));
		pulse(1'b0);
		apb(1, CTRL_ADDR, mk(1, 0, 0, 0, 0, 7, 1));
		apb(0, STATUS_ADDR, 0);
		chk(rd[STAT_CPB], 1, "polarity buffered");
		chk(rd[STAT_ST_LO+:3], 3, "mask z state");
		chk(cfg_eff, 3'h3, "cfg msb ignored");
		chk({dem_en, after_d}, 2'h1, "no demag");
		chk(min_off, MIN_OFF_SENSOR, "min off");
		lvl <= 1'b1;
		wait_z(300);
		chk(got, 0, "z masked early");
		lvl <= 1'b0;
		wait_z(450);
		chk(got, 0, "z masked");
		cyc(150);
		lvl <= 1'b1;
		wait_z(60);
		chk(got, 1, "sensor z");
		cyc(3);
		chk(irq, 1, "irq on");
		apb(0, STATUS_ADDR, 0);
		chk(rd[STAT_ZCF], 1, "flag");
		apb(1, STATUS_ADDR, 1);
		cyc(3);
		chk(irq, 0, "irq cleared");
		$display("test sensor done");
		for (int k = 0; k < 2; k++) begin
			apb(1, CTRL_ADDR, mk(1, 0, 0, 0, 1, 0, 1));
			cyc(120);
			apb(1, CTRL_ADDR, mk(1, 0, 1, 0, 1, 0, 1));
			lvl <= (k != 0);
			cyc(120);
			apb(0, STATUS_ADDR, 0);
			chk(rd[STAT_HST], (k == 0), "latched level");
		end
		$display("test direct done");
		apb(1, MASK_ADDR, 0);
		for (int i = 0; i < 14; i++) begin
			{vcm, os, bemf_read_group_select, edge_level_select, pol} = 7'($urandom);
			{even, odd} <= 2'($urandom);
			lvl <= !pol;
			apb(1, CTRL_ADDR, mk(0, vcm, 0, bemf_read_group_select, pol, os, 0) | (32'(edge_level_select) << CTRL_ZVD));
			pulse(1'b0);
			cyc(810);
			chk({dem_en, after_d, cfg_eff}, {2'b10, os}, "wait d");
			chk(min_off, 12'h064, "min off");
			got = 0;
			repeat (200) begin
				@(posedge pclk);
				got += dem_tick;
			end
			chk(got, 4, "demag tick");
			pulse(1'b1);
			cyc(830);
			lvl <= pol;
			wait_z(30);
			chk(got, permit(vcm, os, bemf_read_group_select, even, odd), "bemf z");
		end
		chk(irq, 0, "irq masked");
		$display("test sensorless done");
		summarize();
	end
endmodule
